// ===== rtl/frs_spi_fram_core.sv
// serial slave command, protection and burst logic for a 2K x 8 array
// Functional notes
// RULE_01 - write latch comes up cleared after reset, so writes are refused
// RULE_02 - latch-set opcode 06h sets the write latch, flag reads one
// RULE_03 - latch-clear opcode 04h clears the write latch, flag reads zero
// RULE_04 - select rising after latch-clear, status write or memory write clears latch
// RULE_05 - status write never changes the latch flag
// RULE_06 - status bits 0 and 4 to 6 read zero, not writable
// RULE_07 - status layout: pin enable bit 7, guard bits 3 and 2, latch bit 1
// RULE_08 - guard bits are held across resets, factory value zero; here reset reloads the zero factory value
// RULE_09 - guard field 00 none, 01 600h up, 10 400h up, 11 all
// RULE_10 - write-protect pin blocks status writes only when pin enable set
// RULE_11 - write-protect pin never affects memory writes
// RULE_12 - status and memory writes refused while the latch is clear
// RULE_13 - status read opcode 05h shifts out one status byte
// RULE_14 - status write opcode 01h updates only pin enable and guard bits
// RULE_15 - master keeps write-protect pin high before status writes
// RULE_16 - write opcode 02h takes two address bytes, low 11 bits used
// RULE_17 - write burst stores and increments, wrapping 7FFh to 000h
// RULE_18 - each byte commits after its eighth bit; partial byte dropped
// RULE_19 - burst reaching protected address stops increment, drops later bytes
// RULE_20 - read opcode 03h plus address drives data MSB first, input ignored
// RULE_21 - read burst increments and wraps; select rising floats output
// RULE_22 - first byte is opcode; unknown opcode ignored until next select
// RULE_23 - input sampled on clock rising, output changed on clock falling
// RULE_24 - clock level at select falling picks mode 0 or mode 3
// RULE_25 - master raises select after each command, one opcode per select
// RULE_26 - status updated only after all eight data bits arrive
`timescale 1ns/100ps
`default_nettype none
`include "frs_regs.svh"
module frs_spi_fram_core
  import frs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spiCs_b,
  input wire logic spiSck,
  input wire logic spiSi,
  input wire logic wrProt_b,
  output logic spiSo,
  output logic spiSoOe_b
);
  localparam logic [3:0] PIN_IDLE = `FRS_PIN_IDLE;
  localparam int AW = `FRS_ADDR_W;
  localparam int DW = `FRS_DATA_W;

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic logic isGuarded(input logic [1:0] guard, input logic [AW-1:0] a);
    case (guard)
      2'h1: isGuarded = (a >= `FRS_GUARD_QUARTER);
      2'h2: isGuarded = (a >= `FRS_GUARD_HALF);
      2'h3: isGuarded = 1'b1;
      default: isGuarded = 1'b0;
    endcase
  endfunction

  function automatic frs_state_e opNext(input logic [DW-1:0] op);
    case (op)
      `FRS_OP_LATCH_SET: opNext = ST_DONE;
      `FRS_OP_LATCH_CLEAR: opNext = ST_DONE;
      `FRS_OP_STATUS_READ: opNext = ST_SRD;
      `FRS_OP_STATUS_WRITE: opNext = ST_SWR;
      `FRS_OP_MEM_READ: opNext = ST_ADDRHI;
      `FRS_OP_MEM_WRITE: opNext = ST_ADDRHI;
      default: opNext = ST_IGNORE;
    endcase
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pinRaw;
  logic [3:0] pinSync;
  assign pinRaw = {wrProt_b, spiSi, spiSck, spiCs_b};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          meta_r <= PIN_IDLE[gi];
          sync_r <= PIN_IDLE[gi];
        end else begin
          meta_r <= pinRaw[gi];
          sync_r <= meta_r;
        end
      end
      assign pinSync[gi] = sync_r;
    end
  endgenerate

  logic csB;
  logic sck;
  logic si;
  logic wpB;
  assign csB = pinSync[0];
  assign sck = pinSync[1];
  assign si = pinSync[2];
  assign wpB = pinSync[3];

  // ------------------------------------------------------------
  // edge detection and mode
  // ------------------------------------------------------------
  logic csPrev_r;
  logic sckPrev_r;
  logic seenRise_r;
  frs_mode_e spiMode_r;
  logic csFall;
  logic csRise;
  logic sckRise;
  logic sckFall;

  assign csFall = ~csB & csPrev_r;
  assign csRise = csB & ~csPrev_r;
  assign sckRise = sck & ~sckPrev_r & ~csB & ~csFall; // RULE_23
  // mode 3 opens with a falling edge that carries no bit
  assign sckFall = ~sck & sckPrev_r & ~csB & (spiMode_r == SPI_MODE0 || seenRise_r); // RULE_23

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      csPrev_r <= 1'b1;
      sckPrev_r <= 1'b0;
    end else begin
      csPrev_r <= csB;
      sckPrev_r <= sck;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      spiMode_r <= SPI_MODE0;
      seenRise_r <= 1'b0;
    end else if (csFall) begin
      spiMode_r <= sck ? SPI_MODE3 : SPI_MODE0; // RULE_24
      seenRise_r <= 1'b0;
    end else if (sckRise) begin
      seenRise_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // bit and byte assembly
  // ------------------------------------------------------------
  frs_state_e state_r;
  logic [2:0] bitCnt_r;
  logic [DW-1:0] sh_r;
  logic [DW-1:0] byteIn;
  logic byteDone;
  logic opDone;
  logic [DW-1:0] cmd_r;

  assign byteIn = {sh_r[DW-2:0], si};
  assign byteDone = sckRise && (bitCnt_r == 3'h7); // RULE_18
  assign opDone = byteDone && (state_r == ST_OPCODE); // RULE_22

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_r <= 3'h0;
      sh_r <= '0;
    end else if (csFall) begin
      bitCnt_r <= 3'h0;
    end else if (sckRise) begin
      bitCnt_r <= bitCnt_r + 3'h1;
      sh_r <= byteIn;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r <= '0;
    end else if (opDone) begin
      cmd_r <= byteIn;
    end
  end

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else if (csRise) begin
      state_r <= ST_IDLE;
    end else if (csFall) begin
      state_r <= ST_OPCODE; // RULE_22
    end else if (byteDone) begin
      case (state_r)
        ST_OPCODE: state_r <= opNext(byteIn); // RULE_22
        ST_ADDRHI: state_r <= ST_ADDRLO; // RULE_16
        ST_ADDRLO: state_r <= (cmd_r == `FRS_OP_MEM_READ) ? ST_RDATA : ST_WDATA;
        ST_SWR: state_r <= ST_DONE;
        default: state_r <= state_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // write latch and status register
  // ------------------------------------------------------------
  logic wel_r;
  logic ppe_r;
  logic [1:0] guard_r;
  logic statusWrOk;
  logic [DW-1:0] statusByte;
  logic endsWrite;

  assign statusWrOk = wel_r && !(ppe_r && !wpB); // RULE_10 RULE_12
  // cmd_r is stale until the opcode completes, so a cut opcode clears nothing
  assign endsWrite = (state_r != ST_OPCODE) && ((cmd_r == `FRS_OP_LATCH_CLEAR) ||
                     (cmd_r == `FRS_OP_STATUS_WRITE) || (cmd_r == `FRS_OP_MEM_WRITE));

  always_comb begin
    statusByte = '0; // RULE_06
    statusByte[`FRS_SR_PIN_PROTECT] = ppe_r; // RULE_07
    statusByte[`FRS_SR_GUARD_HI] = guard_r[1];
    statusByte[`FRS_SR_GUARD_LO] = guard_r[0];
    statusByte[`FRS_SR_WRITE_LATCH] = wel_r;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wel_r <= 1'b0; // RULE_01
    end else if (opDone && byteIn == `FRS_OP_LATCH_SET) begin
      wel_r <= 1'b1; // RULE_02
    end else if (opDone && byteIn == `FRS_OP_LATCH_CLEAR) begin
      wel_r <= 1'b0; // RULE_03
    end else if (csRise && endsWrite && state_r != ST_IDLE) begin
      wel_r <= 1'b0; // RULE_04
    end
  end

  // reset only models the factory value; true retention lives outside this logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ppe_r <= `FRS_SR_PPE_RESET;
      guard_r <= `FRS_SR_GUARD_RESET; // RULE_08
    end else if (byteDone && state_r == ST_SWR && statusWrOk) begin
      ppe_r <= byteIn[`FRS_SR_PIN_PROTECT]; // RULE_14 RULE_26
      guard_r <= {byteIn[`FRS_SR_GUARD_HI], byteIn[`FRS_SR_GUARD_LO]}; // RULE_05
    end
  end

  // ------------------------------------------------------------
  // address counter and write path
  // ------------------------------------------------------------
  logic [2:0] addrHi_r;
  logic [AW-1:0] addr_r;
  logic stop_r;
  logic pushValid_r;
  logic [AW+DW-1:0] pushData_r;
  logic fifoInReady;
  logic wrByte;
  logic wrTake;
  logic rdByte;
  logic rdReq_r;

  assign wrByte = byteDone && (state_r == ST_WDATA);
  // the pin plays no part here, only latch and guard bits
  assign wrTake = wrByte && wel_r && !stop_r && !isGuarded(guard_r, addr_r); // RULE_11 RULE_12 RULE_09
  assign rdByte = byteDone && (state_r == ST_RDATA);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addrHi_r <= 3'h0;
      addr_r <= '0;
    end else if (byteDone && state_r == ST_ADDRHI) begin
      addrHi_r <= byteIn[2:0]; // RULE_16
    end else if (byteDone && state_r == ST_ADDRLO) begin
      addr_r <= {addrHi_r, byteIn};
    end else if (wrTake || rdByte) begin
      addr_r <= addr_r + 11'h001; // RULE_17 RULE_21
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stop_r <= 1'b0;
    end else if (csFall) begin
      stop_r <= 1'b0;
    end else if (wrByte && isGuarded(guard_r, addr_r)) begin
      stop_r <= 1'b1; // RULE_19
    end
  end

  // a held byte waits for fifo room; at link rates it never needs to
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pushValid_r <= 1'b0;
      pushData_r <= '0;
    end else if (wrTake) begin
      pushValid_r <= 1'b1; // RULE_18
      pushData_r <= {addr_r, byteIn};
    end else if (fifoInReady) begin
      pushValid_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdReq_r <= 1'b0;
    end else begin
      rdReq_r <= (byteDone && state_r == ST_ADDRLO && cmd_r == `FRS_OP_MEM_READ) || rdByte; // RULE_20
    end
  end

  // ------------------------------------------------------------
  // fifo and array; reads take the port, draining waits
  // ------------------------------------------------------------
  logic drainValid;
  logic [AW+DW-1:0] drainData;
  logic [DW-1:0] memRdata;

  frs_fifo #(.WIDTH(AW + DW), .DEPTH(`FRS_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .inValid(pushValid_r),
    .inReady(fifoInReady),
    .inData(pushData_r),
    .outValid(drainValid),
    .outReady(~rdReq_r),
    .outData(drainData)
  );

  frs_mem u_mem (
    .mclk(mclk),
    .rst_b(rst_b),
    // idle port follows the burst address so read data never goes stale
    .memAddr((drainValid & ~rdReq_r) ? drainData[AW+DW-1:DW] : addr_r),
    .memWe(drainValid & ~rdReq_r),
    .memWdata(drainData[DW-1:0]),
    .memRdata(memRdata)
  );

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  logic [DW-2:0] outSh_r;
  logic driving;
  logic [DW-1:0] loadByte;

  assign driving = (state_r == ST_SRD) || (state_r == ST_RDATA);
  assign loadByte = (state_r == ST_SRD) ? statusByte : memRdata; // RULE_13

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      spiSo <= 1'b0;
      spiSoOe_b <= 1'b1;
      outSh_r <= '0;
    end else if (csB || !driving) begin
      spiSoOe_b <= 1'b1; // RULE_21 RULE_22
    end else if (sckFall) begin
      spiSoOe_b <= 1'b0; // RULE_23
      if (bitCnt_r == 3'h0) begin
        spiSo <= loadByte[DW-1]; // RULE_20
        outSh_r <= loadByte[DW-2:0];
      end else begin
        spiSo <= outSh_r[DW-2];
        outSh_r <= {outSh_r[DW-3:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_setOp;
    opDone && byteIn == `FRS_OP_LATCH_SET;
  endsequence
  sequence s_clrOp;
    opDone && byteIn == `FRS_OP_LATCH_CLEAR;
  endsequence

  property p_latch_set;
    s_setOp |=> wel_r;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set"); // RULE_02

  property p_latch_clear;
    s_clrOp |=> !wel_r;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared"); // RULE_03

  property p_auto_clear;
    csRise && endsWrite && state_r != ST_IDLE |=> !wel_r;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("latch kept after write"); // RULE_04

  property p_latch_rise;
    $rose(wel_r) |-> $past(opDone) && $past(byteIn) == `FRS_OP_LATCH_SET;
  endproperty
  a_latch_rise: assert property (p_latch_rise) else $error("latch set by other"); // RULE_05

  property p_status_fixed;
    statusByte[6:4] == 3'h0 && !statusByte[0] && statusByte[1] == wel_r;
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status layout"); // RULE_06

  property p_pin_block;
    byteDone && state_r == ST_SWR && ppe_r && !wpB |=> $stable(guard_r) && ppe_r;
  endproperty
  a_pin_block: assert property (p_pin_block) else $error("status write not blocked"); // RULE_10

  property p_guard_push;
    wrByte && (!wel_r || isGuarded(guard_r, addr_r)) |=> $stable(addr_r) && !$rose(pushValid_r);
  endproperty
  a_guard_push: assert property (p_guard_push) else $error("guarded byte stored"); // RULE_09

  property p_stop_hold;
    stop_r && !csFall |=> $stable(addr_r) || $past(state_r) != ST_WDATA;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("address moved after stop"); // RULE_19

  property p_float_end;
    csRise |=> spiSoOe_b [*2];
  endproperty
  a_float_end: assert property (p_float_end) else $error("output driven after select"); // RULE_21

  property p_ignore_float;
    state_r == ST_IGNORE |-> ##1 spiSoOe_b;
  endproperty
  a_ignore_float: assert property (p_ignore_float) else $error("output driven on bad opcode"); // RULE_22

  property p_read_fetch;
    rdByte |=> rdReq_r && addr_r == $past(addr_r) + 11'h001;
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("read fetch missing"); // RULE_21
endmodule
`default_nettype wire

// ===== rtl/frs_regs.svh
// constants for the serial nonvolatile memory slave
`ifndef FRS_REGS_SVH
`define FRS_REGS_SVH
// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define FRS_OP_LATCH_SET 8'h06
`define FRS_OP_LATCH_CLEAR 8'h04
`define FRS_OP_STATUS_READ 8'h05
`define FRS_OP_STATUS_WRITE 8'h01
`define FRS_OP_MEM_READ 8'h03
`define FRS_OP_MEM_WRITE 8'h02
// ------------------------------------------------------------
// status register field positions and reset values
// ------------------------------------------------------------
`define FRS_SR_PIN_PROTECT 7
`define FRS_SR_GUARD_HI 3
`define FRS_SR_GUARD_LO 2
`define FRS_SR_WRITE_LATCH 1
`define FRS_SR_PPE_RESET 1'h0
`define FRS_SR_GUARD_RESET 2'h0
// ------------------------------------------------------------
// array geometry and protected ranges
// ------------------------------------------------------------
`define FRS_ADDR_W 11
`define FRS_DATA_W 8
`define FRS_MEM_DEPTH 2048
`define FRS_FIFO_DEPTH 16
`define FRS_GUARD_QUARTER 11'h600
`define FRS_GUARD_HALF 11'h400
// pin order {wrProt_b, spiSi, spiSck, spiCs_b}, idle levels
`define FRS_PIN_IDLE 4'h9
`endif

// ===== rtl/frs_pkg.sv
// types for the serial nonvolatile memory slave
`default_nettype none
package frs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_ADDRHI, ST_ADDRLO, ST_WDATA,
    ST_RDATA, ST_SRD, ST_SWR, ST_DONE, ST_IGNORE
  } frs_state_e;
  typedef enum logic {SPI_MODE0, SPI_MODE3} frs_mode_e;
endpackage
`default_nettype wire

// ===== rtl/frs_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module frs_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] count_r;
  logic doPush;
  logic doPop;

  assign inReady = (count_r != DEPTH[PW:0]);
  assign outValid = (count_r != '0);
  assign outData = store[rdPtr_r];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      store[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doPush && !doPop) begin
        count_r <= count_r + 1'b1;
      end else if (doPop && !doPush) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/frs_mem.sv
// single port byte array with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "frs_regs.svh"
module frs_mem (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [`FRS_ADDR_W-1:0] memAddr,
  input wire logic memWe,
  input wire logic [`FRS_DATA_W-1:0] memWdata,
  output logic [`FRS_DATA_W-1:0] memRdata
);
  logic [`FRS_DATA_W-1:0] cells [`FRS_MEM_DEPTH];

  always_ff @(posedge mclk) begin
    if (memWe) begin
      cells[memAddr] <= memWdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      memRdata <= '0;
    end else if (!memWe) begin
      memRdata <= cells[memAddr];
    end
  end
endmodule
`default_nettype wire

// ===== testbench/frs_spi_host_model.sv
// spi master model driving the serial memory slave in mode 0 or mode 3
`timescale 1ns/100ps
`default_nettype none
module frs_spi_host_model (
  input wire logic mclk,
  output logic spiCs_b,
  output logic spiSck,
  output logic spiSi,
  input wire logic spiSo,
  input wire logic spiSoOe_b
);
  // ----------------------------------------------------------
  // line state
  // ----------------------------------------------------------
  logic modeHi;
  logic lastMiso = 1'b0;
  logic misoLine;
  // no pull on the line: a floating output shows the inverse of its last bit
  assign misoLine = spiSoOe_b ? ~lastMiso : spiSo;
  initial begin
    spiCs_b = 1'b1;
    spiSck = 1'b0;
    spiSi = 1'b0;
    modeHi = 1'b0;
  end
  always @(posedge mclk) begin
    if (!spiSoOe_b) begin
      lastMiso <= spiSo;
    end
  end
  // ----------------------------------------------------------
  // bus tasks, every change just after an mclk edge
  // ----------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic start(input logic m3);
    modeHi = m3;
    spiSck = m3;
    step(2);
    spiCs_b = 1'b0;
    step(5);
  endtask
  // 160 ns link period; input changes on the fall, read back mid high phase
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      spiSck = 1'b0;
      spiSi = tx[7-i];
      step(4);
      spiSck = 1'b1;
      step(2);
      rx = {rx[6:0], misoLine};
      step(2);
    end
  endtask
  task automatic stop();
    if (!modeHi) begin
      spiSck = 1'b0;
      step(4);
    end
    spiCs_b = 1'b1;
    step(6);
  endtask
endmodule
`default_nettype wire

// ===== testbench/spi_fram_command_protect_access_tb_top.sv
// self-checking bench for the serial memory slave core
`timescale 1ns/100ps
`default_nettype none
`include "frs_regs.svh"
module spi_fram_command_protect_access_tb_top;
  // ----------------------------------------------------------
  // clock, reset, instances
  // ----------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wrProt_b = 1'b1;
  logic spiCs_b, spiSck, spiSi, spiSo, spiSoOe_b;
  logic trackOe = 1'b0;
  logic oeDrove = 1'b0;
  logic [7:0] rx;
  logic [7:0] rd [0:7];
  logic [10:0] prot;
  int fail_count = 0;
  int n_compared = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (trackOe && spiSoOe_b !== 1'b1) begin
      oeDrove <= 1'b1;
    end
  end
  frs_spi_fram_core DUT (.mclk(mclk), .rst_b(rst_b), .spiCs_b(spiCs_b), .spiSck(spiSck),
    .spiSi(spiSi), .wrProt_b(wrProt_b), .spiSo(spiSo), .spiSoOe_b(spiSoOe_b));
  frs_spi_host_model host (.mclk(mclk), .spiCs_b(spiCs_b), .spiSck(spiSck), .spiSi(spiSi),
    .spiSo(spiSo), .spiSoOe_b(spiSoOe_b));
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmd1(input logic [7:0] op);
    host.start(1'b0);
    host.xfer(op, 8, rx);
    host.stop();
  endtask
  task automatic status(input logic m3);
    host.start(m3);
    host.xfer(`FRS_OP_STATUS_READ, 8, rx);
    host.xfer(8'hA5, 8, rx);
    host.stop();
  endtask
  task automatic status_write_cmd(input logic [7:0] v, input int nb);
    host.start(1'b0);
    host.xfer(`FRS_OP_STATUS_WRITE, 8, rx);
    host.xfer(v, nb, rx);
    host.stop();
  endtask
  // upper five address bits sent as ones, they must be ignored
  task automatic mwrite(input logic [10:0] a, input logic [7:0] b0, input int nb, input int part);
    host.start(1'b0);
    host.xfer(`FRS_OP_MEM_WRITE, 8, rx);
    host.xfer({5'h1F, a[10:8]}, 8, rx);
    host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < nb; i++) host.xfer(b0 + 8'(i), 8, rx);
    if (part > 0) host.xfer(8'hFF, part, rx);
    host.stop();
  endtask
  task automatic mread(input logic [10:0] a, input int nb);
    host.start(1'b0);
    host.xfer(`FRS_OP_MEM_READ, 8, rx);
    host.xfer({5'h1F, a[10:8]}, 8, rx);
    host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < nb; i++) host.xfer(8'h5A, 8, rd[i]);
    host.stop();
    chk("so float", {7'h00, spiSoOe_b}, 8'h01);
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    chk("idle float", {7'h00, spiSoOe_b}, 8'h01);
    status(1'b0);
    chk("status after reset", rx, 8'h00);
  endtask
  task automatic t_latch();
    cmd1(`FRS_OP_LATCH_SET);
    status(1'b0);
    chk("latch set", rx, 8'h02);
    status(1'b1);
    chk("latch set mode3", rx, 8'h02);
    cmd1(`FRS_OP_LATCH_CLEAR);
    status(1'b0);
    chk("latch clear", rx, 8'h00);
  endtask
  task automatic t_status();
    status_write_cmd(8'hFF, 8);
    status(1'b0);
    chk("status_write_cmd no latch", rx, 8'h00);
    cmd1(`FRS_OP_LATCH_SET);
    status_write_cmd(8'hFF, 8);
    status(1'b0);
    chk("status_write_cmd all ones", rx, 8'h8C);
    cmd1(`FRS_OP_LATCH_SET);
    status_write_cmd(8'h00, 4);
    status(1'b0);
    chk("status_write_cmd cut short", rx, 8'h8C);
    cmd1(`FRS_OP_LATCH_SET);
    wrProt_b = 1'b0;
    status_write_cmd(8'h00, 8);
    status(1'b0);
    chk("status_write_cmd pin blocked", rx, 8'h8C);
    wrProt_b = 1'b1;
    cmd1(`FRS_OP_LATCH_SET);
    status_write_cmd(8'h7F, 8);
    status(1'b0);
    chk("status_write_cmd keeps latch bit", rx, 8'h0C);
    cmd1(`FRS_OP_LATCH_SET);
    wrProt_b = 1'b0;
    status_write_cmd(8'h00, 8);
    status(1'b0);
    chk("status_write_cmd pin ignored", rx, 8'h00);
    wrProt_b = 1'b1;
  endtask
  task automatic t_wrap();
    cmd1(`FRS_OP_LATCH_SET);
    mwrite(11'h001, 8'h5A, 1, 0);
    cmd1(`FRS_OP_LATCH_SET);
    mwrite(11'h7FE, 8'hA1, 3, 4);
    mread(11'h7FE, 4);
    chk("wrap 7FE", rd[0], 8'hA1);
    chk("wrap 7FF", rd[1], 8'hA2);
    chk("wrap 000", rd[2], 8'hA3);
    chk("partial dropped", rd[3], 8'h5A);
    mwrite(11'h7FE, 8'h00, 1, 0);
    mread(11'h7FE, 1);
    chk("write no latch", rd[0], 8'hA1);
  endtask
  // guard codes 01, 10, 11 with the pin low during array writes
  task automatic t_guard();
    for (int i = 0; i < 3; i++) begin
      prot = (i == 0) ? `FRS_GUARD_QUARTER : ((i == 1) ? `FRS_GUARD_HALF : 11'h000);
      cmd1(`FRS_OP_LATCH_SET);
      mwrite(prot - 11'h001, 8'h3C, 2, 0);
    end
    for (int g = 1; g < 4; g++) begin
      prot = (g == 1) ? `FRS_GUARD_QUARTER : ((g == 2) ? `FRS_GUARD_HALF : 11'h000);
      wrProt_b = 1'b1;
      cmd1(`FRS_OP_LATCH_SET);
      status_write_cmd({1'b1, 3'h0, 2'(g), 2'h0}, 8);
      wrProt_b = 1'b0;
      cmd1(`FRS_OP_LATCH_SET);
      mwrite(prot - 11'h001, 8'hC3, 1, 0);
      cmd1(`FRS_OP_LATCH_SET);
      mwrite(prot, 8'hC3, 1, 0);
      mread(prot - 11'h001, 2);
      chk("below guard", rd[0], (g == 3) ? 8'h3C : 8'hC3);
      chk("guard start", rd[1], 8'h3D);
    end
    wrProt_b = 1'b1;
    cmd1(`FRS_OP_LATCH_SET);
    status_write_cmd(8'h84, 8);
    cmd1(`FRS_OP_LATCH_SET);
    mwrite(11'h5FE, 8'h11, 4, 0);
    mread(11'h5FE, 3);
    chk("burst 5FE", rd[0], 8'h11);
    chk("burst 5FF", rd[1], 8'h12);
    chk("burst stopped", rd[2], 8'h3D);
  endtask
  task automatic t_unknown();
    trackOe = 1'b1;
    host.start(1'b0);
    host.xfer(8'hFF, 8, rx);
    host.xfer(`FRS_OP_LATCH_SET, 8, rx);
    host.xfer(`FRS_OP_STATUS_READ, 8, rx);
    host.stop();
    trackOe = 1'b0;
    chk("unknown op drove", {7'h00, oeDrove}, 8'h00);
    status(1'b0);
    chk("unknown op latch", rx, 8'h84);
  endtask
  // ----------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    t_reset();
    t_latch();
    t_status();
    t_wrap();
    t_guard();
    t_unknown();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
